// ===== shared/sarseq_pkg.sv
// package for the sar conversion sequencer: timing, states, carriers
// assumes a 100 MHz core clock; all counts derive from the figures here
package sarseq_pkg;

	// core clock period in picoseconds
	localparam int unsigned CLK_PERIOD_PS = 10000;
	// longest conversion time, ns
	localparam int unsigned CONV_MAX_NS = 660;
	// least acquisition time at full rate, ns
	localparam int unsigned ACQ_MIN_NS = 327;
	// reinitialisation window after power-on reset, us
	localparam int unsigned REINIT_US = 200;
	// conversion cycles, longest time rounds down
	localparam int unsigned CONV_CYCLES = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
	// acquisition cycles, least time rounds up
	localparam int unsigned ACQ_CYCLES =
		(ACQ_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// reinit cycles, least time rounds up
	localparam int unsigned REINIT_CYCLES =
		(REINIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// result width
	localparam int unsigned DATA_W = 32;
	// full-scale codes of the plain and expanded transfer
	localparam logic [31:0] CODE_POS_FS = 32'h7fffffff;
	localparam logic [31:0] CODE_NEG_FS = 32'h80000000;
	localparam logic [31:0] CODE_POS_EXP = 32'h407fffff;
	localparam logic [31:0] CODE_NEG_EXP = 32'hbf800000;
	// reset values
	localparam logic RST_BUSY = 1'b0;
	localparam logic RST_PWR = 1'b0;

	// sequencer states
	typedef enum logic [1:0] {
		SARSEQ_REINIT = 2'b00,
		SARSEQ_ACQ = 2'b01,
		SARSEQ_CONV = 2'b10
	} sarseq_state_type;

	// gain settings carried together
	typedef struct packed {
		logic gain_compression_enable;
		logic gain_expansion_enable;
	} sarseq_gain_type;

	// result carried with its validity
	typedef struct packed {
		logic [DATA_W-1:0] code;
		logic invalid;
	} sarseq_result_type;

endpackage

// ===== rtl/sarseq_scale.sv
// output code scaling for gain compression and expansion
// assumes raw is a signed code of the full +/-vref span
`timescale 1ns/1ps
`default_nettype none
module sarseq_scale (
	// raw code and gain settings
	input  wire logic [31:0]                raw_i,
	input  wire sarseq_pkg::sarseq_gain_type gain_i,
	// scaled code
	output logic [31:0]                      code_o
);
	import sarseq_pkg::*;

	logic signed [33:0] raw_s;   // sign-extended raw
	logic signed [33:0] comp_s;  // after compression (x 1.25)
	logic signed [33:0] exp_s;   // after expansion (halved)
	logic signed [33:0] hi_s;    // upper saturation code
	logic signed [33:0] lo_s;    // lower saturation code
	logic signed [33:0] lim_s;   // saturated span

	// compression first, then expansion, saturation last so that
	// expansion really widens the span instead of halving a clipped code
	always_comb begin
		raw_s = {{2{raw_i[31]}}, raw_i};
		hi_s = 34'sh07fffffff;
		lo_s = -34'sh080000000;
		if (gain_i.gain_compression_enable) begin
			comp_s = raw_s + (raw_s >>> 2);
		end else begin
			comp_s = raw_s;
		end
		if (gain_i.gain_expansion_enable) begin
			exp_s = comp_s >>> 1;
			hi_s = 34'sh0407fffff;
			lo_s = -34'sh040800000;
		end else begin
			exp_s = comp_s;
		end
		// saturate at the limits of the active mode
		if (exp_s > hi_s) begin
			lim_s = hi_s;
		end else if (exp_s < lo_s) begin
			lim_s = lo_s;
		end else begin
			lim_s = exp_s;
		end
		code_o = lim_s[31:0];
	end
endmodule
`default_nettype wire

// ===== rtl/sarseq_top.sv
// conversion sequencer: strobe edge, busy, auto power-down, reinit window
// assumes strobe is synchronous to core_clk_i; raw code from the sar core
`timescale 1ns/1ps
`default_nettype none
// Function
// - strobe rising edge powers up, converts
// - strobe edges ignored during conversion
// - busy high throughout conversion
// - completion powers down, acquires next sample
// - conversion ends within bounded time
// - no minimum acquisition interval enforced; a strobe seen right after completion starts at once
// - power-on reset reinitialises converter
// - conversions in reinit window flagged invalid
// - last result held while powered down
// - compression maps reduced span to full scale
// - expansion widens compressed span slightly
//
// timing overview, one line per clock edge:
//   edge 0  strobe seen high after low, in acquisition: start
//   edge 1  busy, core power high, acquisition flag low
//   edge 67 busy low, core powered down, result updated
// a strobe rise while busy is dropped without any indication,
// so the host must space strobes by at least 67 edges
// the reinit timer runs beside the sequencer; starts made before
// it expires still convert but are marked invalid in the result
// power-on reset from the supply monitor restarts that timer
// and drops any conversion in flight without updating the result
// the clock enable freezes every register, timers included
module sarseq_top #(
	parameter int unsigned REINIT_N = sarseq_pkg::REINIT_CYCLES
) (
	// clock, reset, enable
	input  wire logic                          core_clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          ce_i,
	// power-on reset from supply monitor
	input  wire logic                          por_i,
	// host strobe and gain settings
	input  wire logic                          sample_strobe_i,
	input  wire sarseq_pkg::sarseq_gain_type   gain_i,
	// raw code from the core
	input  wire logic [31:0]                   raw_code_i,
	// status and result
	output logic                               busy_o,
	output logic                               core_power_o,
	output logic                               acquiring_o,
	output logic                               ready_o,
	output sarseq_pkg::sarseq_result_type      result_o
);
	import sarseq_pkg::*;

	localparam logic [6:0] CONV_LAST = 7'(CONV_CYCLES - 1);
	localparam logic [24:0] REINIT_LAST = 25'(REINIT_N - 1);

	sarseq_state_type  state_q, state_d;      // sequencer state
	logic [6:0]        conv_cnt_q, conv_cnt_d; // conversion timer
	logic [24:0]       init_cnt_q, init_cnt_d; // reinit timer
	logic              strobe_q, strobe_d;     // strobe last value
	logic              inval_q, inval_d;       // conversion started early
	logic              busy_q, busy_d;         // busy flag
	logic              pwr_q, pwr_d;           // core powered
	logic              acq_q, acq_d;           // acquiring input
	logic              ready_q, ready_d;       // reinit over
	sarseq_result_type res_q, res_d;           // held result
	logic [31:0]       scaled;                 // scaled raw code
	logic              rise;                   // strobe rising edge

	// scaler for the gain modes
	sarseq_scale u_scale (
		.raw_i  (raw_code_i),
		.gain_i (gain_i),
		.code_o (scaled)
	);

	assign rise = sample_strobe_i & ~strobe_q;

	// next-state logic
	always_comb begin
		state_d = state_q;
		conv_cnt_d = conv_cnt_q;
		init_cnt_d = init_cnt_q;
		strobe_d = sample_strobe_i;
		inval_d = inval_q;
		busy_d = busy_q;
		pwr_d = pwr_q;
		ready_d = ready_q;
		res_d = res_q;
		if (por_i) begin
			state_d = SARSEQ_REINIT;
			init_cnt_d = '0;
			ready_d = 1'b0;
			busy_d = 1'b0;
			pwr_d = 1'b0;
		end else begin
			// reinit window timer runs in any state
			if (!ready_q) begin
				if (init_cnt_q == REINIT_LAST) begin
					ready_d = 1'b1;
				end else begin
					init_cnt_d = init_cnt_q + 25'd1;
				end
			end
			case (state_q)
				SARSEQ_REINIT: begin
					state_d = SARSEQ_ACQ;
					busy_d = 1'b0;
					pwr_d = 1'b0;
				end
				SARSEQ_ACQ: begin
					if (rise) begin
						state_d = SARSEQ_CONV;
						conv_cnt_d = '0;
						busy_d = 1'b1;
						pwr_d = 1'b1;
						inval_d = ~ready_q;
					end
				end
				SARSEQ_CONV: begin
					if (conv_cnt_q == CONV_LAST) begin
						state_d = SARSEQ_ACQ;
						busy_d = 1'b0;
						pwr_d = 1'b0;
						res_d.code = scaled;
						res_d.invalid = inval_q;
					end else begin
						conv_cnt_d = conv_cnt_q + 7'd1;
					end
				end
				default: begin
					// unused code: back to reinit
					state_d = SARSEQ_REINIT;
				end
			endcase
		end
		acq_d = ~pwr_d;
	end

	// registers, frozen while the clock enable is low
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_q <= SARSEQ_REINIT;
			conv_cnt_q <= '0;
			init_cnt_q <= '0;
			strobe_q <= 1'b0;
			inval_q <= 1'b0;
			busy_q <= RST_BUSY;
			pwr_q <= RST_PWR;
			acq_q <= ~RST_PWR;
			ready_q <= 1'b0;
			res_q <= '0;
		end else if (ce_i) begin
			state_q <= state_d;
			conv_cnt_q <= conv_cnt_d;
			init_cnt_q <= init_cnt_d;
			strobe_q <= strobe_d;
			inval_q <= inval_d;
			busy_q <= busy_d;
			pwr_q <= pwr_d;
			acq_q <= acq_d;
			ready_q <= ready_d;
			res_q <= res_d;
		end
	end

	assign busy_o = busy_q;
	assign core_power_o = pwr_q;
	assign acquiring_o = acq_q;
	assign ready_o = ready_q;
	assign result_o = res_q;
endmodule
`default_nettype wire

// ===== tb/sarseq_top_assertions.sv
// checker on the sequencer top ports
// assumes ce_i stays high over a checked span
`timescale 1ns/1ps
`default_nettype none
module sarseq_top_assertions #(
	parameter int unsigned REINIT_N = 20
) (
	// clock and controls
	input wire logic                          core_clk_i,
	input wire logic                          rst_i,
	input wire logic                          ce_i,
	input wire logic                          por_i,
	input wire logic                          sample_strobe_i,
	// status and result
	input wire logic                          busy_o,
	input wire logic                          core_power_o,
	input wire logic                          acquiring_o,
	input wire logic                          ready_o,
	input wire sarseq_pkg::sarseq_result_type result_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i || !ce_i);
	AST_START: assert property (
		!busy_o && $rose(sample_strobe_i) && !$past(rst_i) && !por_i &&
		!$past(por_i) |=> busy_o)
		else $error("no start on strobe");
	AST_READY_KEEP: assert property (
		ready_o && !por_i |=> ready_o)
		else $error("ready dropped without por");
	AST_CONV_LEN: assert property (
		$rose(busy_o) |-> (busy_o throughout ##65 1'h1) ##1 !busy_o)
		else $error("busy length wrong");
	AST_POWER: assert property (
		core_power_o == busy_o && acquiring_o != core_power_o)
		else $error("power state wrong");
	AST_STAY: assert property (
		!busy_o && !$rose(sample_strobe_i) |=> !busy_o)
		else $error("start without strobe");
	AST_HELD: assert property (
		!$past(rst_i) && !$fell(busy_o) |-> $stable(result_o))
		else $error("result moved");
	AST_INVALID: assert property (
		$rose(busy_o) |-> ##66 (result_o.invalid == !$past(ready_o, 67)))
		else $error("invalid flag wrong");
	AST_POR_CLR: assert property (por_i |=> !ready_o)
		else $error("ready kept after por");
	AST_IDLE: assert property (
		$fell(rst_i) |-> !busy_o && acquiring_o && !ready_o)
		else $error("not idle after reset");
endmodule
bind sarseq_top sarseq_top_assertions #(.REINIT_N(REINIT_N))
	sarseq_top_assertions_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.ce_i(ce_i), .por_i(por_i), .sample_strobe_i(sample_strobe_i),
	.busy_o(busy_o), .core_power_o(core_power_o),
	.acquiring_o(acquiring_o), .ready_o(ready_o), .result_o(result_o));
`default_nettype wire

// ===== tb/sarseq_host_model.sv
// host model: one fire request gives one short strobe pulse
// assumes fire_i moves on the falling edge
`timescale 1ns/1ps
`default_nettype none
module sarseq_host_model (
	// clock and request
	input wire logic clk_i,
	input wire logic fire_i,
	// strobe to the sequencer
	output var logic strobe_o
);
	logic [1:0] hi_q; // cycles left high
	initial begin
		strobe_o = 1'h0;
		hi_q = 2'h0;
	end
	always @(negedge clk_i) begin
		if (fire_i && !strobe_o) begin
			strobe_o <= 1'h1;
			hi_q <= 2'h2;
		end else if (hi_q != 2'h0) begin
			hi_q <= hi_q - 2'h1;
		end else begin
			strobe_o <= 1'h0;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_sarseq_top.sv
// bench for the sequencer: queued expectations, monitor compares
// assumes the host model drives the strobe
`timescale 1ns/1ps
`default_nettype none
module tb_sarseq_top;
	import sarseq_pkg::*;
	logic core_clk_i, rst_i, ce_i, por_i, fire, strb, pb;
	logic busy, pwr, acq, rdy;
	logic [31:0] raw;
	sarseq_gain_type gain;
	sarseq_result_type res;
	sarseq_result_type q[$]; // expected results
	int bad_count = 0;
	int n_compared = 0;
	initial begin
		core_clk_i = 1'h0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	sarseq_top #(.REINIT_N(20)) sarseq_top_i (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .ce_i(ce_i), .por_i(por_i), .sample_strobe_i(strb),
		.gain_i(gain), .raw_code_i(raw), .busy_o(busy), .core_power_o(pwr),
		.acquiring_o(acq), .ready_o(rdy), .result_o(res));
	sarseq_host_model sarseq_host_model_i (.clk_i(core_clk_i),
		.fire_i(fire), .strobe_o(strb));
	function automatic logic [31:0] scale(logic [31:0] r, sarseq_gain_type g);
		longint v;
		longint hi;
		v = longint'(signed'(r));
		hi = g.gain_expansion_enable ? CODE_POS_EXP : CODE_POS_FS;
		if (g.gain_compression_enable)
			v = v * 5 / 4;
		if (g.gain_expansion_enable)
			v = v >>> 1;
		if (v > hi)
			v = hi;
		if (v < -hi - 1)
			v = -hi - 1;
		return v[31:0];
	endfunction
	task automatic chk(sarseq_result_type e, sarseq_result_type g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one conversion, optional extra strobe mid-way
	task automatic conv(sarseq_gain_type g, logic [31:0] r, logic bad, mid);
		gain = g;
		raw = r;
		q.push_back({scale(r, g), bad});
		fire <= 1'h1;
		@(negedge core_clk_i) fire <= 1'h0;
		if (mid) begin
			repeat (20) @(negedge core_clk_i);
			fire <= 1'h1;
			@(negedge core_clk_i) fire <= 1'h0;
			repeat (5) @(negedge core_clk_i);
			ce_i <= 1'h0;
			repeat (4) @(negedge core_clk_i);
			ce_i <= 1'h1;
		end
		repeat (100) @(negedge core_clk_i);
	endtask
	// result watcher
	always @(posedge core_clk_i) begin
		pb <= busy;
		if (pb && !busy) begin
			if (q.size() == 0)
				chk('x, res);
			else
				chk(q.pop_front(), res);
		end
	end
	initial begin
		void'($urandom(55));
		{rst_i, ce_i, por_i, fire, gain, raw} = {4'hc, 34'h0};
		repeat (8) @(negedge core_clk_i);
		rst_i = 1'h0;
		conv(2'h0, 32'h100, 1'h1, 1'h0);
		for (int i = 0; i < 16; i++)
			conv(i[1:0], i[3] ? (i[2] ? 32'h7ffffff8 : 32'h80000000)
				: $urandom & 32'hfffffff8, 1'h0, i == 5);
		por_i = 1'h1;
		@(negedge core_clk_i) por_i = 1'h0;
		conv(2'h3, $urandom & 32'hfffffff8, 1'h1, 1'h0);
		end_of_test;
	end
	initial begin
		#100000;
		bad_count++;
		end_of_test;
	end
endmodule
`default_nettype wire
